// ---- rtl/lutdp_ram.sv ----
// Purpose: 16x1 dual-port / 16x1 single-port distributed RAM
// Assumes: clk_sys_i is the write clock; inputs synchronous to it
// Notes:   Reads are combinational; no read-side state
// Function
// - Dual-port mode joins both copies into one 16x1 array, two reads
// - Write at one address, read another, same cycle, no interference
// - Read and write at same address in one cycle are both valid
// - Dual-port mode always writes on the clock edge, never level
// - Primary address reads first copy and writes both copies
// - First read output shows stored bit at primary address, except d_i during a level-mode write
// - Second copy reads at second address in dual-port mode, else at primary; writes at primary address
// - Dual-port mode: second read output shows stored bit at second read address
// - Level mode writes data while write enable is high, latch-like
// - Level mode: data change during enable stores new data
// - Level mode: address change during enable corrupts locations
// - Synchronous write leaves read path combinational
`timescale 1ns/1ps
`default_nettype none
module lutdp_ram
  import lutdp_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire lutdp_mode_e mode_i,
  input  wire logic        d_i,
  input  wire lutdp_addr_t addr_i,
  input  wire lutdp_addr_t second_read_addr_i,
  input  wire logic        we_i,
  output logic             first_read_out_o,
  output logic             second_read_out_o,
  output logic             level_addr_hazard_o
);

  lutdp_state_s st;
  lutdp_state_s next_st;
  logic         level_mode;
  logic         level_wr;
  lutdp_addr_t  rd_addr [LUTDP_NPORT];
  lutdp_mem_t   rd_mem  [LUTDP_NPORT];
  logic         rd_out  [LUTDP_NPORT];

  // One-hot write decode
  function automatic lutdp_mem_t wr_mask(input lutdp_addr_t a);
    lutdp_mem_t m;
    m = '0;
    m[a] = 1'b1;
    return m;
  endfunction

  // Dual-port mode can never select level timing
  assign level_mode = (mode_i == LUTDP_LEVEL_SP);
  assign level_wr   = level_mode && we_i;
  assign level_addr_hazard_o = level_wr && st.last_we
                               && (addr_i != st.last_addr);

  always_comb
  begin
    lutdp_mem_t m;
    m = wr_mask(addr_i);
    next_st = st;
    next_st.last_addr = addr_i;
    next_st.last_we   = level_wr;
    if (we_i)
    begin
      // Same write lands in both copies
      next_st.f_mem = d_i ? (st.f_mem | m) : (st.f_mem & ~m);
      next_st.g_mem = d_i ? (st.g_mem | m) : (st.g_mem & ~m);
      if (level_addr_hazard_o)
      begin
        // Spurious write to the old address as well
        m = wr_mask(st.last_addr);
        next_st.f_mem = d_i ? (next_st.f_mem | m) : (next_st.f_mem & ~m);
        next_st.g_mem = d_i ? (next_st.g_mem | m) : (next_st.g_mem & ~m);
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st.f_mem     <= LUTDP_INIT;
      st.g_mem     <= LUTDP_INIT;
      st.last_addr <= LUTDP_ADDR_RST;
      st.last_we   <= 1'b0;
    end
    else
      st <= next_st;
  end

  // Second port uses its own address only in dual-port mode
  assign rd_addr[LUTDP_PORT_F] = addr_i;
  assign rd_addr[LUTDP_PORT_G] = (mode_i == LUTDP_EDGE_DP)
                                 ? second_read_addr_i : addr_i;
  assign rd_mem[LUTDP_PORT_F]  = st.f_mem;
  assign rd_mem[LUTDP_PORT_G]  = st.g_mem;

  // Combinational read ports
  generate
    for (genvar p = 0; p < LUTDP_NPORT; p++)
    begin : g_rd
      lutdp_rdport u_rd
      (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .mem_i      (rd_mem[p]),
        .addr_i     (rd_addr[p]),
        .bypass_i   (level_wr),
        .bypass_d_i (d_i),
        .rd_o       (rd_out[p])
      );
    end
  endgenerate

  assign first_read_out_o  = rd_out[LUTDP_PORT_F];
  assign second_read_out_o = rd_out[LUTDP_PORT_G];

  // Checks
  wr_both_copies_a: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (we_i && !level_mode) |=>
      st.f_mem[$past(addr_i)] == $past(d_i)
      && st.g_mem[$past(addr_i)] == $past(d_i))
    else $error("Edge write missed a storage copy");

  first_port_read_a: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (we_i && !level_mode) ##1 ($stable(addr_i) && !level_mode)
      |-> first_read_out_o == $past(d_i))
    else $error("First output does not show written bit");

  second_port_read_a: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (we_i && mode_i == LUTDP_EDGE_DP) ##1
      (mode_i == LUTDP_EDGE_DP && second_read_addr_i == $past(addr_i))
      |-> second_read_out_o == $past(d_i))
    else $error("Second output does not show written bit");

  indep_read_a: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (mode_i == LUTDP_EDGE_DP && we_i && second_read_addr_i != addr_i)
      ##1 (mode_i == LUTDP_EDGE_DP && $stable(second_read_addr_i))
      |-> $stable(second_read_out_o))
    else $error("Write disturbed an independent read");

  same_addr_rw_a: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (mode_i == LUTDP_EDGE_DP && we_i && second_read_addr_i == addr_i)
      |-> (second_read_out_o == st.g_mem[addr_i])
      ##1 (st.g_mem[$past(addr_i)] == $past(d_i)))
    else $error("Same-address read and write not both valid");

  dual_edge_only_a: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (mode_i == LUTDP_EDGE_DP && we_i)
      |-> first_read_out_o == st.f_mem[addr_i] && !level_addr_hazard_o)
    else $error("Dual-port mode showed level-sensitive behaviour");

  level_transp_a: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    level_wr |-> first_read_out_o == d_i && second_read_out_o == d_i)
    else $error("Level write not transparent");

  level_newdata_a: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    level_wr ##1 (level_wr && $stable(addr_i) && $changed(d_i))
      |=> st.f_mem[$past(addr_i)] == $past(d_i))
    else $error("Level write lost the new data");

  level_spurious_a: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    level_wr ##1 (level_wr && $changed(addr_i))
      |-> level_addr_hazard_o
      ##1 st.f_mem[$past(st.last_addr)] == $past(d_i))
    else $error("Address change during level write not flagged");

  dp_write_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    mode_i == LUTDP_EDGE_DP && we_i && second_read_addr_i != addr_i);

  dp_same_addr_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    mode_i == LUTDP_EDGE_DP && we_i && second_read_addr_i == addr_i);

  level_pulse_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    !level_wr ##1 level_wr [*3] ##1 !level_wr);

  level_hazard_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    level_addr_hazard_o);

endmodule
`default_nettype wire

// ---- rtl/lutdp_pkg.sv ----
// Purpose: Shared constants and types for the LUT dual-port RAM
// Assumes: One write clock, reads are combinational
// Notes:   Initial content stands in for configuration-time load
package lutdp_pkg;

  localparam int          LUTDP_ADDR_W  = 4;
  localparam int          LUTDP_DEPTH   = 16;
  localparam int          LUTDP_NPORT   = 2;
  localparam int          LUTDP_PORT_F  = 0;
  localparam int          LUTDP_PORT_G  = 1;
  localparam logic [15:0] LUTDP_INIT    = 16'h0000;
  localparam logic [3:0]  LUTDP_ADDR_RST = 4'h0;

  typedef enum logic [1:0]
  {
    LUTDP_EDGE_SP,
    LUTDP_EDGE_DP,
    LUTDP_LEVEL_SP
  } lutdp_mode_e;

  typedef logic [LUTDP_ADDR_W-1:0] lutdp_addr_t;
  typedef logic [LUTDP_DEPTH-1:0]  lutdp_mem_t;

  typedef struct packed
  {
    lutdp_mem_t  f_mem;
    lutdp_mem_t  g_mem;
    lutdp_addr_t last_addr;
    logic        last_we;
  } lutdp_state_s;

endpackage

// ---- rtl/lutdp_rdport.sv ----
// Purpose: One combinational read port of a 16x1 storage copy
// Assumes: Address is applied directly, no read register
// Notes:   Bypass gives latch transparency in level-sensitive mode
`timescale 1ns/1ps
`default_nettype none
module lutdp_rdport
  import lutdp_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire lutdp_mem_t  mem_i,
  input  wire lutdp_addr_t addr_i,
  input  wire logic        bypass_i,
  input  wire logic        bypass_d_i,
  output logic             rd_o
);

  // Read mux, optionally transparent to the data input
  always_comb
  begin
    if (bypass_i)
      rd_o = bypass_d_i;
    else
      rd_o = mem_i[addr_i];
  end

  bypass_path_a: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    bypass_i |-> rd_o == bypass_d_i)
    else $error("Read port not transparent during bypass");

  stored_path_a: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    !bypass_i |-> rd_o == mem_i[addr_i])
    else $error("Read port does not follow address");

endmodule
`default_nettype wire

// ---- verif/lutdp_user.sv ----
// Purpose: User logic model driving the RAM write side
// Assumes: All outputs change just after a rising clk_sys_i edge
// Notes:   Write pointer on primary address, read pointer on second
`timescale 1ns/1ps
`default_nettype none
module lutdp_user
  import lutdp_pkg::*;
(
  input  wire logic      clk_sys_i,
  output var logic       we_o,
  output var logic       d_o,
  output var lutdp_addr_t addr_o,
  output var lutdp_addr_t sraddr_o
);
  initial
  begin
    we_o     = 1'b0;
    d_o      = 1'b0;
    addr_o   = '0;
    sraddr_o = '0;
  end

  // One cycle of user traffic, whole cycle wide
  task automatic drive(input logic we, input lutdp_addr_t a, input logic d,
                       input lutdp_addr_t ra);
    @(posedge clk_sys_i);
    we_o     <= we;
    d_o      <= d;
    addr_o   <= a;
    sraddr_o <= ra;
  endtask
endmodule
`default_nettype wire

// ---- verif/lutdp_ram_tb.sv ----
// Purpose: Self-checking bench for the LUT dual-port RAM
// Assumes: Inputs change at rising edge, outputs sampled at falling
// Notes:   A mirror array predicts both read ports
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("BAD %s exp %0h got %0h", nm, e, g); \
    end \
  end
module lutdp_ram_tb
  import lutdp_pkg::*;
;
  localparam lutdp_mem_t PAT = 16'hA5C3;
  logic        clk_sys_i;
  logic        rst_i;
  lutdp_mode_e mode_i;
  logic        d_i;
  logic        we_i;
  logic        rd1;
  logic        rd2;
  logic        haz;
  lutdp_addr_t addr_i;
  lutdp_addr_t sra;
  lutdp_addr_t prev_a;
  logic        prev_we;
  lutdp_mem_t  mirror;
  int          bad_count;
  int          checks_done;

  lutdp_user user_u (.clk_sys_i(clk_sys_i), .we_o(we_i), .d_o(d_i),
                     .addr_o(addr_i), .sraddr_o(sra));
  lutdp_ram dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .mode_i(mode_i),
                   .d_i(d_i), .addr_i(addr_i), .second_read_addr_i(sra),
                   .we_i(we_i), .first_read_out_o(rd1),
                   .second_read_out_o(rd2), .level_addr_hazard_o(haz));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  task automatic final_report();
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One cycle: drive, check before the write edge, update mirror
  task automatic step(input logic we, input lutdp_addr_t a, input logic d,
                      input lutdp_addr_t ra);
    lutdp_addr_t sa;
    logic        lv;
    logic        hz;
    user_u.drive(we, a, d, ra);
    sa = (mode_i == LUTDP_EDGE_DP) ? ra : a;
    lv = (mode_i == LUTDP_LEVEL_SP) && we;
    hz = lv && prev_we && (a != prev_a);
    @(negedge clk_sys_i);
    `CHK("first", lv ? d : mirror[a], rd1)
    `CHK("second", lv ? d : mirror[sa], rd2)
    `CHK("hazard", hz, haz)
    if (we)
    begin
      mirror[a] = d;
      if (hz)
        mirror[prev_a] = d;
    end
    prev_a  = a;
    prev_we = we;
  endtask

  task automatic set_mode(input lutdp_mode_e m);
    @(posedge clk_sys_i);
    mode_i <= m;
  endtask

  task automatic t_reset();
    step(1'b0, 4'h0, 1'b0, 4'h0);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    mirror  = '0;
    prev_we = 1'b0;
    for (int i = 0; i < 16; i++)
      step(1'b0, 4'(i), 1'b1, 4'(15 - i));
    $display("done reset");
  endtask

  task automatic t_fill();
    set_mode(LUTDP_EDGE_DP);
    for (int i = 0; i < 16; i++)
      step(1'b1, 4'(i), PAT[i], 4'(i + 8));
    for (int i = 0; i < 16; i++)
      step(1'b0, 4'(i), ~PAT[i], 4'(15 - i));
    step(1'b1, 4'h5, 1'b1, 4'h5);
    step(1'b1, 4'h5, 1'b0, 4'h5);
    step(1'b0, 4'h5, 1'b1, 4'h5);
    $display("done fill");
  endtask

  task automatic t_modes();
    lutdp_mode_e ms [2];
    ms = '{LUTDP_EDGE_SP, LUTDP_EDGE_DP};
    foreach (ms[k])
    begin
      set_mode(ms[k]);
      step(1'b1, 4'h9, ~mirror[9], 4'h2);
      step(1'b0, 4'h9, 1'b0, 4'h2);
    end
    $display("done modes");
  endtask

  task automatic t_level();
    set_mode(LUTDP_LEVEL_SP);
    step(1'b0, 4'h3, 1'b0, 4'h0);
    step(1'b1, 4'h3, 1'b1, 4'h0);
    step(1'b1, 4'h3, 1'b0, 4'h0);
    step(1'b1, 4'h4, 1'b1, 4'h0);
    step(1'b0, 4'h3, 1'b0, 4'h0);
    step(1'b0, 4'h4, 1'b0, 4'h0);
    set_mode(LUTDP_EDGE_DP);
    $display("done level");
  endtask

  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    bad_count++;
    final_report();
  end

  initial
  begin
    rst_i       = 1'b1;
    mode_i      = LUTDP_EDGE_DP;
    mirror      = '0;
    prev_a      = '0;
    prev_we     = 1'b0;
    bad_count   = 0;
    checks_done = 0;
    t_reset();
    t_fill();
    t_modes();
    t_level();
    t_reset();
    final_report();
  end
endmodule
`default_nettype wire
